// file: verilog/tsc_pkg.sv
// tsc_pkg: register map, control fields, state codes and timing of the two-wire controller
package tsc_pkg;
  localparam int unsigned ADDR_W = 12;
  // register indices; the byte address is four times the index
  localparam logic [7:0] IDX_CONTROL    = 8'hE9;
  localparam logic [7:0] IDX_OWN_ADDR   = 8'hEA;
  localparam logic [7:0] IDX_DATA       = 8'hEC;
  localparam logic [7:0] IDX_STATE      = 8'hED;
  localparam logic [7:0] IDX_BIT_RATE   = 8'hEE;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'hF8;
  localparam logic [7:0] IDX_IRQ_MASK   = 8'hF9;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'hFA;
  // twi_control fields
  localparam int unsigned CTL_ENABLE = 6;
  localparam int unsigned CTL_BEGIN  = 5;
  localparam int unsigned CTL_HALT   = 4;
  localparam int unsigned CTL_SI     = 3;
  localparam int unsigned CTL_ACK    = 2;
  localparam int unsigned CTL_INBLK  = 1;
  // interrupt register fields
  localparam int unsigned IRQ_STATE_BIT  = 0;
  localparam int unsigned IRQ_BUSERR_BIT = 1;
  localparam int unsigned IEN_SERIAL_BIT = 0;
  localparam int unsigned IEN_GLOBAL_BIT = 1;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] RESET_IRQ  = 2'h0;
  // state codes
  localparam logic [7:0] C_BUS_ERROR     = 8'h00;
  localparam logic [7:0] C_START         = 8'h08;
  localparam logic [7:0] C_RSTART        = 8'h10;
  localparam logic [7:0] C_MT_SLA_ACK    = 8'h18;
  localparam logic [7:0] C_MT_SLA_NACK   = 8'h20;
  localparam logic [7:0] C_MT_DATA_ACK   = 8'h28;
  localparam logic [7:0] C_MT_DATA_NACK  = 8'h30;
  localparam logic [7:0] C_ARB_LOST      = 8'h38;
  localparam logic [7:0] C_MR_SLA_ACK    = 8'h40;
  localparam logic [7:0] C_MR_SLA_NACK   = 8'h48;
  localparam logic [7:0] C_MR_DATA_ACK   = 8'h50;
  localparam logic [7:0] C_MR_DATA_NACK  = 8'h58;
  localparam logic [7:0] C_SR_SLA_ACK    = 8'h60;
  localparam logic [7:0] C_SR_GC_ACK     = 8'h70;
  localparam logic [7:0] C_SR_DATA_ACK   = 8'h80;
  localparam logic [7:0] C_SR_DATA_NACK  = 8'h88;
  localparam logic [7:0] C_SR_GCD_ACK    = 8'h90;
  localparam logic [7:0] C_SR_GCD_NACK   = 8'h98;
  localparam logic [7:0] C_SR_STOP       = 8'hA0;
  localparam logic [7:0] C_ST_SLA_ACK    = 8'hA8;
  localparam logic [7:0] C_ST_DATA_ACK   = 8'hB8;
  localparam logic [7:0] C_ST_DATA_NACK  = 8'hC0;
  localparam logic [7:0] C_IDLE          = 8'hF8;
  // bit timing: half scl period = (twi_bit_rate + 1) << HALF_SHIFT cycles
  localparam int unsigned HALF_SHIFT = 2;
  localparam logic [3:0] BITS_ACK  = 4'h8;
  localparam logic [3:0] BITS_DONE = 4'h9;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    PH_IDLE, PH_START, PH_XFER, PH_HOLD, PH_STOP
  } tsc_phase_type;
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [7:0] idx);
    reg_hit = (a[ADDR_W-1:2] == {2'h0, idx});
  endfunction
endpackage

// file: verilog/tsc_top.sv
// tsc_top: two-wire serial controller with an AXI4-Lite register slave
// Notes on behaviour
// - serial function runs only while bus_unit_enable is set
// - begin_request enters master mode, sends START or repeated START when free
// - halt_request in master mode sends STOP; cleared when STOP is seen
// - halt_request in slave mode returns to not-addressed unless set while the slave holds scl after a byte; no STOP driven
// - each new state code sets the flag; interrupt needs both enables
// - hardware never clears the flag; software clears it to continue
// - acknowledge pulse drives data low when ack_assert is one, else high
// - data_input_block or power-down blocks the data line input
// - slave compares received address with own-address bits 7-1
// - general_call_enable makes the slave answer address 00H
// - state register reads code in upper five bits, low three zero
// - code F8H sets no flag; every other code sets it
// - code valid with the flag, held one cycle after it clears
// - START or STOP inside a byte reports code 00H; not while the acknowledge clock is high
// - data register holds byte to send or last byte received
// - bit-rate register sets master clock rate
`timescale 1ns/1ps
`default_nettype none
module tsc_top import tsc_pkg::*; (
  input  wire logic              clock_i,
  input  wire logic              rstn_i,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  input  wire logic              scl_i,
  output logic                   scl_o,
  output logic                   scl_oe_o,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_o,
  input  wire logic              power_down_i,
  output logic                   irq_o
);
  logic          rst_meta, rst_n;
  logic          scl_m, scl_s, scl_d, sda_m, sda_s, sda_d, bus_busy;
  logic          bus_unit_enable, begin_request, halt_request, si;
  logic          ack_assert, data_input_block;
  logic [7:0]    own_addr, data_reg, state_code, bit_rate;
  logic [1:0]    irq_status, irq_mask, irq_en;
  tsc_phase_type phase;
  logic          is_master, listening, addressed, tx, addr_byte, rw;
  logic          gc_hit, got_ack, ev, ev_err;
  logic [7:0]    ev_code, shift;
  logic [3:0]    bit_cnt;
  logic [1:0]    step;
  logic [10:0]   tim;

  // reset release through two flops
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // open-drain pins only ever pull low
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;

  // blocking is applied after the synchroniser so its first flop stays clean
  wire sda_seen = sda_s | data_input_block | power_down_i;
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
    end else begin
      {scl_m, scl_s, scl_d} <= {scl_i, scl_m, scl_s};
      {sda_m, sda_s}        <= {sda_i, sda_m};
      sda_d                 <= sda_seen;
    end
  end

  wire scl_rise  = scl_s & ~scl_d;
  wire scl_fall  = ~scl_s & scl_d;
  wire start_det = scl_s & scl_d & sda_d & ~sda_seen;
  wire stop_det  = scl_s & scl_d & ~sda_d & sda_seen;

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      bus_busy <= 1'b0;
    end else if (start_det) begin
      bus_busy <= 1'b1;
    end else if (stop_det) begin
      bus_busy <= 1'b0;
    end
  end

  // ---------------- register slave ----------------
  wire [7:0] wb = s_axi_wdata_i[7:0];
  wire wr_do = s_axi_awready_o & s_axi_awvalid_i & s_axi_wvalid_i;
  wire wr_go = s_axi_awvalid_i & s_axi_wvalid_i & ~s_axi_awready_o
             & ~s_axi_bvalid_o;
  wire wr_en = wr_do & s_axi_wstrb_i[0];
  wire wr_ctl  = wr_en & reg_hit(s_axi_awaddr_i, IDX_CONTROL);
  wire wr_own  = wr_en & reg_hit(s_axi_awaddr_i, IDX_OWN_ADDR);
  wire wr_dat  = wr_en & reg_hit(s_axi_awaddr_i, IDX_DATA);
  wire wr_rate = wr_en & reg_hit(s_axi_awaddr_i, IDX_BIT_RATE);
  wire wr_ist  = wr_en & reg_hit(s_axi_awaddr_i, IDX_IRQ_STATUS);
  wire wr_imk  = wr_en & reg_hit(s_axi_awaddr_i, IDX_IRQ_MASK);
  wire wr_ien  = wr_en & reg_hit(s_axi_awaddr_i, IDX_IRQ_ENABLE);
  wire wr_map  = reg_hit(s_axi_awaddr_i, IDX_CONTROL)
               | reg_hit(s_axi_awaddr_i, IDX_OWN_ADDR)
               | reg_hit(s_axi_awaddr_i, IDX_DATA)
               | reg_hit(s_axi_awaddr_i, IDX_STATE)
               | reg_hit(s_axi_awaddr_i, IDX_BIT_RATE)
               | reg_hit(s_axi_awaddr_i, IDX_IRQ_STATUS)
               | reg_hit(s_axi_awaddr_i, IDX_IRQ_MASK)
               | reg_hit(s_axi_awaddr_i, IDX_IRQ_ENABLE);

  wire rd_go = s_axi_arvalid_i & ~s_axi_arready_o & ~s_axi_rvalid_o;
  wire rd_do = s_axi_arready_o & s_axi_arvalid_i;
  wire [7:0] ctl_rd = {1'b0, bus_unit_enable, begin_request, halt_request,
                       si, ack_assert, data_input_block, 1'b0};
  wire [7:0] rd_byte =
      reg_hit(s_axi_araddr_i, IDX_CONTROL)    ? ctl_rd :
      reg_hit(s_axi_araddr_i, IDX_OWN_ADDR)   ? own_addr :
      reg_hit(s_axi_araddr_i, IDX_DATA)       ? data_reg :
      reg_hit(s_axi_araddr_i, IDX_STATE)      ? {state_code[7:3], 3'h0} :
      reg_hit(s_axi_araddr_i, IDX_BIT_RATE)   ? bit_rate :
      reg_hit(s_axi_araddr_i, IDX_IRQ_STATUS) ? {6'h00, irq_status} :
      reg_hit(s_axi_araddr_i, IDX_IRQ_MASK)   ? {6'h00, irq_mask} :
      reg_hit(s_axi_araddr_i, IDX_IRQ_ENABLE) ? {6'h00, irq_en} : 8'h00;
  wire rd_map = reg_hit(s_axi_araddr_i, IDX_CONTROL)
              | reg_hit(s_axi_araddr_i, IDX_OWN_ADDR)
              | reg_hit(s_axi_araddr_i, IDX_DATA)
              | reg_hit(s_axi_araddr_i, IDX_STATE)
              | reg_hit(s_axi_araddr_i, IDX_BIT_RATE)
              | reg_hit(s_axi_araddr_i, IDX_IRQ_STATUS)
              | reg_hit(s_axi_araddr_i, IDX_IRQ_MASK)
              | reg_hit(s_axi_araddr_i, IDX_IRQ_ENABLE);

  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o  <= 1'b0;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= RESP_OKAY;
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rresp_o   <= RESP_OKAY;
      s_axi_rdata_o   <= 32'h00000000;
    end else begin
      s_axi_awready_o <= wr_go;
      s_axi_wready_o  <= wr_go;
      s_axi_arready_o <= rd_go;
      if (wr_do) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o  <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
      if (rd_do) begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o  <= rd_map ? RESP_OKAY : RESP_SLVERR;
        s_axi_rdata_o  <= {24'h000000, rd_byte};
      end else if (s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

  // ---------------- bus engine helpers ----------------
  wire [10:0] half_len = 11'(({3'h0, bit_rate} + 11'h001) << HALF_SHIFT);
  wire tick      = (tim == 11'h000);
  wire xfer_on   = (phase == PH_XFER) | ((phase == PH_IDLE) & listening);
  wire in_byte   = (bit_cnt != 4'h0) & (bit_cnt != BITS_DONE);
  wire bus_err   = (start_det | stop_det) & xfer_on & in_byte;
  wire byte_done = scl_fall & xfer_on & (bit_cnt == BITS_DONE) & ~bus_err;
  wire data_bit  = data_reg[3'h7 - bit_cnt[2:0]];
  wire addr_match = (shift[7:1] == own_addr[7:1]);
  wire gc_match   = (shift[7:1] == 7'h00) & own_addr[0];
  wire halt_clr  = stop_det | (halt_request & ~is_master);
  wire [7:0] m_code =
      addr_byte ? (rw ? (got_ack ? C_MR_SLA_ACK : C_MR_SLA_NACK)
                      : (got_ack ? C_MT_SLA_ACK : C_MT_SLA_NACK)) :
      tx        ? (got_ack ? C_MT_DATA_ACK : C_MT_DATA_NACK)
                : (got_ack ? C_MR_DATA_ACK : C_MR_DATA_NACK);
  wire [7:0] s_code =
      addr_byte ? (gc_hit ? C_SR_GC_ACK : (rw ? C_ST_SLA_ACK : C_SR_SLA_ACK)) :
      tx        ? (got_ack ? C_ST_DATA_ACK : C_ST_DATA_NACK) :
      gc_hit    ? (got_ack ? C_SR_GCD_ACK : C_SR_GCD_NACK)
                : (got_ack ? C_SR_DATA_ACK : C_SR_DATA_NACK);

  // ---------------- software registers ----------------
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      bus_unit_enable  <= 1'b0;
      begin_request    <= 1'b0;
      halt_request     <= 1'b0;
      si               <= 1'b0;
      ack_assert       <= 1'b0;
      data_input_block <= 1'b0;
      own_addr         <= RESET_BYTE;
      data_reg         <= RESET_BYTE;
      bit_rate         <= RESET_BYTE;
      state_code       <= C_IDLE;
      irq_status       <= RESET_IRQ;
      irq_mask         <= RESET_IRQ;
      irq_en           <= RESET_IRQ;
      irq_o            <= 1'b0;
    end else begin
      if (wr_ctl) begin
        bus_unit_enable  <= wb[CTL_ENABLE];
        begin_request    <= wb[CTL_BEGIN];
        ack_assert       <= wb[CTL_ACK];
        data_input_block <= wb[CTL_INBLK];
      end
      if (wr_ctl) begin
        halt_request <= wb[CTL_HALT];
      end else if (halt_clr) begin
        halt_request <= 1'b0;
      end
      // a new state beats a same-cycle clear; writing one never sets
      if (ev) begin
        si <= 1'b1;
      end else if (wr_ctl && !wb[CTL_SI]) begin
        si <= 1'b0;
      end
      if (ev) begin
        state_code <= ev_code;
      end else if (!si) begin
        state_code <= C_IDLE;
      end
      if (byte_done) begin
        data_reg <= shift;
      end else if (wr_dat) begin
        data_reg <= wb;
      end
      if (wr_own) begin
        own_addr <= wb;
      end
      if (wr_rate) begin
        bit_rate <= wb;
      end
      if (wr_imk) begin
        irq_mask <= wb[1:0];
      end
      if (wr_ien) begin
        irq_en <= wb[1:0];
      end
      irq_status[IRQ_STATE_BIT] <= ev |
        (irq_status[IRQ_STATE_BIT] & ~(wr_ist & wb[IRQ_STATE_BIT]));
      irq_status[IRQ_BUSERR_BIT] <= ev_err |
        (irq_status[IRQ_BUSERR_BIT] & ~(wr_ist & wb[IRQ_BUSERR_BIT]));
      irq_o <= (|(irq_status & irq_mask)) & irq_en[IEN_GLOBAL_BIT]
             & irq_en[IEN_SERIAL_BIT];
    end
  end

  // ---------------- bus engine ----------------
  always_ff @(posedge clock_i or negedge rst_n) begin
    if (!rst_n) begin
      phase <= PH_IDLE;
      {is_master, listening, addressed, tx, addr_byte} <= 5'h00;
      {rw, gc_hit, got_ack, ev, ev_err} <= 5'h00;
      {scl_oe_o, sda_oe_o} <= 2'h0;
      ev_code <= C_IDLE;
      shift   <= RESET_BYTE;
      bit_cnt <= 4'h0;
      step    <= 2'h0;
      tim     <= 11'h000;
    end else if (!bus_unit_enable) begin
      phase <= PH_IDLE;
      {is_master, listening, addressed, tx, addr_byte} <= 5'h00;
      {ev, ev_err, scl_oe_o, sda_oe_o} <= 4'h0;
      bit_cnt <= 4'h0;
    end else begin
      ev     <= 1'b0;
      ev_err <= 1'b0;
      if (!tick) begin
        tim <= tim - 11'h001;
      end
      if (bus_err) begin
        phase <= PH_IDLE;
        {is_master, listening, addressed, scl_oe_o, sda_oe_o} <= 5'h00;
        {ev, ev_err} <= 2'h3;
        ev_code <= C_BUS_ERROR;
      end else begin
        if (start_det) begin
          bit_cnt   <= 4'h0;
          addr_byte <= 1'b1;
          tx        <= is_master;
        end
        if ((start_det | stop_det) & ~is_master) begin
          listening <= start_det;
          addressed <= 1'b0;
          if (addressed) begin
            ev      <= 1'b1;
            ev_code <= C_SR_STOP;
          end
        end
        if (scl_rise & xfer_on) begin
          if (bit_cnt < BITS_ACK) begin
            shift <= {shift[6:0], sda_seen};
          end else begin
            got_ack <= ~sda_seen;
          end
          bit_cnt <= bit_cnt + 4'h1;
          // released a one but the line reads low: another master won
          if (is_master & tx & (bit_cnt < BITS_ACK) & ~sda_oe_o
              & ~sda_seen) begin
            phase     <= PH_IDLE;
            is_master <= 1'b0;
            scl_oe_o  <= 1'b0;
            ev        <= 1'b1;
            ev_code   <= C_ARB_LOST;
          end
        end
        if (scl_fall & xfer_on) begin
          if (bit_cnt == BITS_DONE) begin
            bit_cnt   <= 4'h0;
            addr_byte <= 1'b0;
            sda_oe_o  <= 1'b0;
            scl_oe_o  <= 1'b1;
            phase     <= PH_HOLD;
            ev        <= 1'b1;
            ev_code   <= is_master ? m_code : s_code;
            if (addr_byte) begin
              tx <= is_master ? ~rw : rw;
            end else if (~is_master & ~got_ack) begin
              {addressed, listening} <= 2'h0;
            end
          end else if (bit_cnt == BITS_ACK) begin
            if (tx) begin
              sda_oe_o <= 1'b0;
              if (addr_byte) begin
                rw <= shift[0];
              end
            end else if (~is_master & addr_byte) begin
              if ((addr_match | gc_match) & ack_assert) begin
                sda_oe_o  <= 1'b1;
                addressed <= 1'b1;
                gc_hit    <= gc_match;
                rw        <= shift[0];
              end else begin
                sda_oe_o  <= 1'b0;
                listening <= 1'b0;
              end
            end else begin
              sda_oe_o <= ack_assert;
            end
          end else begin
            sda_oe_o <= tx & ~data_bit;
          end
        end
        unique case (phase)
          PH_IDLE: begin
            if (halt_request & ~is_master) begin
              {listening, addressed} <= 2'h0;
            end else if (begin_request & ~bus_busy & ~si & ~listening) begin
              is_master <= 1'b1;
              phase     <= PH_START;
              step      <= 2'h1;
              tim       <= half_len;
              ev_code   <= C_START;
            end
          end
          PH_HOLD: begin
            // the pair ev/si covers the cycle before si is seen high
            if (~si & ~ev) begin
              tim <= half_len;
              if (~is_master) begin
                phase    <= PH_IDLE;
                scl_oe_o <= 1'b0;
                sda_oe_o <= listening & tx & ~data_reg[7];
              end else if (halt_request) begin
                phase    <= PH_STOP;
                step     <= 2'h0;
                sda_oe_o <= 1'b1;
              end else if (begin_request) begin
                phase    <= PH_START;
                step     <= 2'h0;
                sda_oe_o <= 1'b0;
                ev_code  <= C_RSTART;
              end else begin
                phase    <= PH_XFER;
                sda_oe_o <= tx & ~data_reg[7];
              end
            end
          end
          PH_XFER: begin
            // a slow slave holding scl low stretches the low phase; the high count starts once scl reads high
            if (scl_oe_o) begin
              if (tick) begin
                scl_oe_o <= 1'b0;
                tim      <= half_len;
              end
            end else if (~scl_s) begin
              tim <= half_len;
            end else if (tick) begin
              scl_oe_o <= 1'b1;
              tim      <= half_len;
            end
          end
          PH_START: begin
            if (tick & ((step != 2'h1) | scl_s)) begin
              tim  <= half_len;
              step <= step + 2'h1;
              if (step == 2'h0) begin
                scl_oe_o <= 1'b0;
              end else if (step == 2'h1) begin
                sda_oe_o <= 1'b1;
              end else begin
                scl_oe_o <= 1'b1;
                phase    <= PH_HOLD;
                // code chosen at launch: our own START already marks the
                // bus busy, so it cannot tell a first from a repeated one
                ev       <= 1'b1;
              end
            end
          end
          PH_STOP: begin
            if (tick & ((step != 2'h1) | scl_s)) begin
              tim  <= half_len;
              step <= step + 2'h1;
              if (step == 2'h0) begin
                scl_oe_o <= 1'b0;
              end else if (step == 2'h1) begin
                sda_oe_o <= 1'b0;
              end else begin
                phase     <= PH_IDLE;
                is_master <= 1'b0;
              end
            end
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// file: sim/tsc_props.sv
// tsc_props: port protocol checks for the two-wire controller
`timescale 1ns/1ps
`default_nettype none
module tsc_props (
  input wire logic        clock_i,
  input wire logic        rstn_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wready_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_arready_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic        scl_o,
  input wire logic        sda_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  aw_w_pair_a: assert property (s_axi_awready_o == s_axi_wready_o)
    else $error("write ready halves differ");
  aw_pulse_a: assert property (s_axi_awready_o |=> !s_axi_awready_o)
    else $error("awready longer than one cycle");
  wr_answer_a: assert property (s_axi_awready_o |=> s_axi_bvalid_o)
    else $error("no write response after handshake");
  b_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped early");
  rd_answer_a: assert property (s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("no read data after handshake");
  r_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped early");
  r_upper_zero_a: assert property (
    s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h000000)
    else $error("read data upper bits set");
  pins_drive_low_a: assert property (scl_o == 1'b0 && sda_o == 1'b0)
    else $error("open-drain pin drives high");
endmodule
bind tsc_top tsc_props u_props (.clock_i(clock_i), .rstn_i(rstn_i),
  .s_axi_awready_o(s_axi_awready_o), .s_axi_wready_o(s_axi_wready_o),
  .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
  .s_axi_bresp_o(s_axi_bresp_o), .s_axi_arready_o(s_axi_arready_o),
  .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
  .s_axi_rdata_o(s_axi_rdata_o), .scl_o(scl_o), .sda_o(sda_o));
`default_nettype wire

// file: sim/tsc_slave_model.sv
// tsc_slave_model: behavioural addressed slave on the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module tsc_slave_model #(parameter logic [6:0] MY_ADDR = 7'h2A) (
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_oe_o,
  output logic [7:0]      rx_o,
  output logic            stop_o
);
  int n;
  initial begin
    sda_oe_o = 1'b0;
    rx_o = 8'h00;
    stop_o = 1'b0;
    n = 10;
  end
  always @(negedge sda_i) if (scl_i) begin
    n = 0;
    stop_o = 1'b0;
  end
  always @(posedge sda_i) if (scl_i) stop_o = 1'b1;
  always @(posedge scl_i) if (n < 8) begin
    rx_o = {rx_o[6:0], sda_i};
    n++;
  end
  // ack only on own address; line released at the next falling clock
  always @(negedge scl_i) begin
    if (n == 8) begin
      sda_oe_o = (rx_o[7:1] == MY_ADDR);
      n = 9;
    end else if (n == 9) begin
      sda_oe_o = 1'b0;
      n = 10;
    end
  end
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// tb_top: directed register and bus-transfer scenarios for the controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %s expected %h seen %h", n, e, g); end end
module tb_top;
  import tsc_pkg::*;
  logic              clock_i = 1'b0;
  logic              rstn_i = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0]       wdata = '0, rdata;
  logic              awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
  logic              awrdy, wrdy, bvalid, arrdy, rvalid, irq, p_oe, p_stop;
  logic              scl_o, scl_oe, sda_o, sda_oe;
  logic [1:0]        bresp, rresp;
  logic [7:0]        p_rx;
  int                n_errors = 0, checks = 0;
  // pulled-up wires; port latches tied low so only the enables pull low
  wire logic scl_w = scl_oe ? scl_o : 1'b1;
  wire logic sda_w = (sda_oe ? sda_o : 1'b1) & ~p_oe;
  always #10 clock_i = ~clock_i;
  tsc_top uut (.clock_i(clock_i), .rstn_i(rstn_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awvalid_i(awv), .s_axi_awready_o(awrdy), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy),
    .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv), .s_axi_arready_o(arrdy),
    .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_o(scl_oe),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe), .power_down_i(1'b0),
    .irq_o(irq));
  tsc_slave_model #(.MY_ADDR(7'h2A)) partner (.scl_i(scl_w), .sda_i(sda_w),
    .sda_oe_o(p_oe), .rx_o(p_rx), .stop_o(p_stop));
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] idx, d, input logic [1:0] er);
    int t;
    t = 0;
    @(posedge clock_i);
    awaddr <= {2'h0, idx, 2'h0};
    wdata <= {24'h000000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do @(posedge clock_i); while (awrdy !== 1'b1 && ++t < 50);
    awv <= 1'b0;
    wv <= 1'b0;
    do @(posedge clock_i); while (bvalid !== 1'b1 && ++t < 50);
    bready <= 1'b0;
    `CHK("bresp", er, bresp)
  endtask
  task automatic rd(input logic [7:0] idx, ed, input logic [1:0] er);
    int t;
    t = 0;
    @(posedge clock_i);
    araddr <= {2'h0, idx, 2'h0};
    arv <= 1'b1;
    rready <= 1'b1;
    do @(posedge clock_i); while (arrdy !== 1'b1 && ++t < 50);
    arv <= 1'b0;
    do @(posedge clock_i); while (rvalid !== 1'b1 && ++t < 50);
    rready <= 1'b0;
    `CHK("rdata", {24'h000000, ed}, rdata)
    `CHK("rresp", er, rresp)
  endtask
  task automatic wait_irq();
    int t;
    t = 0;
    while (irq !== 1'b1 && t < 3000) begin
      @(posedge clock_i);
      t++;
    end
    `CHK("irq", 1'b1, irq)
  endtask
  task automatic t_regs();
    rd(IDX_CONTROL, 8'h00, RESP_OKAY);
    rd(IDX_STATE, C_IDLE, RESP_OKAY);
    wr(IDX_OWN_ADDR, 8'hA5, RESP_OKAY);
    rd(IDX_OWN_ADDR, 8'hA5, RESP_OKAY);
    wr(IDX_DATA, 8'h3C, RESP_OKAY);
    rd(IDX_DATA, 8'h3C, RESP_OKAY);
    wr(IDX_BIT_RATE, 8'h01, RESP_OKAY);
    rd(IDX_BIT_RATE, 8'h01, RESP_OKAY);
    wr(8'h40, 8'h11, RESP_SLVERR);
    rd(8'h40, 8'h00, RESP_SLVERR);
    $display("test regs done");
  endtask
  // one addressed write attempt: START, address byte, then STOP
  task automatic t_master(input logic [6:0] a, input logic [7:0] code);
    wr(IDX_IRQ_MASK, 8'h01, RESP_OKAY);
    wr(IDX_IRQ_ENABLE, 8'h03, RESP_OKAY);
    wr(IDX_CONTROL, 8'h64, RESP_OKAY);
    wait_irq();
    rd(IDX_STATE, C_START, RESP_OKAY);
    rd(IDX_CONTROL, 8'h6C, RESP_OKAY);
    wr(IDX_IRQ_STATUS, 8'h01, RESP_OKAY);
    wr(IDX_DATA, {a, 1'b0}, RESP_OKAY);
    wr(IDX_CONTROL, 8'h44, RESP_OKAY);
    wait_irq();
    `CHK("rx byte", {a, 1'b0}, p_rx)
    rd(IDX_STATE, code, RESP_OKAY);
    wr(IDX_IRQ_STATUS, 8'h01, RESP_OKAY);
    wr(IDX_CONTROL, 8'h54, RESP_OKAY);
    for (int t = 0; t < 3000 && p_stop !== 1'b1; t++) @(posedge clock_i);
    repeat (4) @(posedge clock_i);
    `CHK("stop seen", 1'b1, p_stop)
    rd(IDX_CONTROL, 8'h44, RESP_OKAY);
    rd(IDX_STATE, C_IDLE, RESP_OKAY);
    $display("test master %h done", a);
  endtask
  initial begin
    repeat (3) @(posedge clock_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    t_regs();
    t_master(7'h2A, C_MT_SLA_ACK);
    t_master(7'h15, C_MT_SLA_NACK);
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clock_i);
    n_errors++;
    test_done();
  end
endmodule
`default_nettype wire
